// ### common/dcct_params.svh
`ifndef DCCT_PARAMS_SVH
`define DCCT_PARAMS_SVH

// register indexes; byte address is four times the index
`define DCCT_IDX_BYTE_CTRL 4'h0
`define DCCT_IDX_SHARED 4'h1
`define DCCT_IDX_WORD_CTRL 4'h2
`define DCCT_IDX_RUN_SYNC 4'h3
`define DCCT_IDX_BYTE_HOLD_LO 4'h4
`define DCCT_IDX_BYTE_HOLD_HI 4'h5
`define DCCT_IDX_WORD_HOLD_LO 4'h6
`define DCCT_IDX_WORD_HOLD_HI 4'h7
`define DCCT_IDX_WORD_CAP_LO 4'h8
`define DCCT_IDX_WORD_CAP_HI 4'h9
`define DCCT_IDX_BYTE_CAP_LO 4'hA
`define DCCT_IDX_BYTE_CAP_HI 4'hB

// byte and word counter control fields
`define DCCT_CTL_RUN 7
`define DCCT_CTL_ONESHOT 6
`define DCCT_CTL_TIMEOUT 5
`define DCCT_CTL_CLK_HI 4
`define DCCT_CTL_CLK_LO 3
`define DCCT_CTL_BYTE_CAPMODE 2
`define DCCT_CTL_WORD_CAPIE 2
`define DCCT_CTL_TOIE 1
`define DCCT_CTL_PINSEL 0

// shared counter control fields
`define DCCT_SH_SEL_ALT 7
`define DCCT_SH_EDGE_HI 5
`define DCCT_SH_EDGE_LO 4
`define DCCT_SH_IGNORE 3
`define DCCT_SH_DEMOD 2
`define DCCT_SH_FLAG_RISE 1
`define DCCT_SH_FLAG_FALL 0

// run and sync control fields
`define DCCT_RS_WORD_RUN 7
`define DCCT_RS_BYTE_RUN 6
`define DCCT_RS_SYNC 5
`define DCCT_RS_RSVD 5'h1F

// reset values and fixed counts
`define DCCT_BYTE_RST 8'h00
`define DCCT_WORD_RST 16'h0000
`define DCCT_BYTE_FULL 8'hFF

`endif

// ### common/dcct_pkg.sv
package dcct_pkg;
    typedef logic [7:0] dcct_byte_t;
    typedef logic [15:0] dcct_word_t;
    typedef logic [2:0] dcct_pre_t;
endpackage

// ### hw/dcct_counter.sv
`timescale 1ns/1ps
`default_nettype none
// reloadable down counter with terminal count pulse
module dcct_counter #(
    parameter int WIDTH = 8
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic tick_in,
    input wire logic run_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] load_val_in,
    output logic [WIDTH-1:0] count_out,
    output logic tc_out
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic tc_reg;
    logic tc_next;

    // load wins; at zero reload and flag terminal count
    always_comb
    begin
        count_next = count_reg;
        tc_next = 1'b0;
        if (load_in)
        begin
            count_next = load_val_in;
        end
        else if (run_in && tick_in)
        begin
            if (count_reg == '0)
            begin
                count_next = load_val_in;
                tc_next = 1'b1;
            end
            else
            begin
                count_next = count_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            count_reg <= '0;
            tc_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tc_reg <= tc_next;
        end
    end

    assign count_out = count_reg;
    assign tc_out = tc_reg;
endmodule // dcct_counter
`default_nettype wire

// ### hw/dcct_timers.sv
`include "dcct_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dcct_timers
    import dcct_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic comparator_capable_input_in,
    input wire logic alternate_edge_input_in,
    input wire logic word_port_data_in,
    input wire logic byte_port_data_in,
    output logic word_counter_output_pin_out,
    output logic byte_counter_output_pin_out,
    output logic interrupt_line_three_out,
    output logic interrupt_line_four_out
);
    // register state
    dcct_byte_t byte_ctrl_reg, byte_ctrl_next;
    dcct_byte_t shared_reg, shared_next;
    dcct_byte_t word_ctrl_reg, word_ctrl_next;
    logic sync_reg, sync_next;
    dcct_byte_t byte_hold_lo_reg, byte_hold_lo_next;
    dcct_byte_t byte_hold_hi_reg, byte_hold_hi_next;
    dcct_word_t word_hold_reg, word_hold_next;
    dcct_word_t word_cap_reg, word_cap_next;
    dcct_byte_t byte_cap_lo_reg, byte_cap_lo_next;
    dcct_byte_t byte_cap_hi_reg, byte_cap_hi_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wait_reg, wait_next;
    // counter side state
    dcct_pre_t pre_reg, pre_next;
    logic [1:0] sync1_reg, sync2_reg;
    logic prev_reg, prev_next;
    logic byte_out_reg, byte_out_next;
    logic word_out_reg, word_out_next;
    logic word_prev_reg, word_prev_next;
    logic edge_seen_reg, edge_seen_next;
    logic byte_run_q_reg, word_run_q_reg;
    logic word_pin_reg, word_pin_next;
    logic byte_pin_reg, byte_pin_next;
    logic interrupt_line_three_reg, interrupt_line_three_next;
    logic interrupt_line_four_reg, interrupt_line_four_next;
    // combinational helpers
    logic wr_take, rd_take;
    logic [3:0] idx;
    dcct_byte_t wd;
    logic lvl, rise, fall, demod_edge, word_cap_ev, byte_cap_ev;
    logic byte_tick, word_tick, byte_load, word_load, sync_align;
    dcct_byte_t byte_count, byte_ld;
    dcct_word_t word_count;
    logic byte_tc, word_tc;

    // prescaler tick for a two-bit clock select
    function automatic logic pre_tick(input logic [1:0] sel,
                                      input dcct_pre_t pre);
        logic t;
        t = 1'b1;
        case (sel)
            2'h1: t = pre[0];
            2'h2: t = &pre[1:0];
            2'h3: t = &pre;
            default: t = 1'b1;
        endcase
        return t;
    endfunction

    // bus handshake terms; one wait cycle then one ready cycle
    assign idx = avs_address_in[5:2];
    assign wd = avs_writedata_in[7:0];
    assign wr_take = avs_write_in && !wait_reg && avs_byteenable_in[0];
    assign rd_take = avs_read_in && wait_reg;

    // edge input selection and edge detection
    assign lvl = shared_reg[`DCCT_SH_SEL_ALT] ? sync2_reg[1]
                                               : sync2_reg[0];
    assign rise = lvl && !prev_reg;
    assign fall = !lvl && prev_reg;
    always_comb
    begin
        case (shared_reg[`DCCT_SH_EDGE_HI:`DCCT_SH_EDGE_LO])
            2'h0: demod_edge = fall;
            2'h1: demod_edge = rise;
            default: demod_edge = rise || fall;
        endcase
    end
    // first edge only when ignore bit set
    assign word_cap_ev = shared_reg[`DCCT_SH_DEMOD] && word_ctrl_reg[7]
        && demod_edge
        && !(shared_reg[`DCCT_SH_IGNORE] && edge_seen_reg);
    assign byte_cap_ev = byte_ctrl_reg[`DCCT_CTL_BYTE_CAPMODE]
        && byte_ctrl_reg[`DCCT_CTL_RUN] && (rise || fall);

    // free running prescaler gives a partial first tick
    assign byte_tick = pre_tick(byte_ctrl_reg[4:3], pre_reg);
    assign word_tick = pre_tick(word_ctrl_reg[4:3], pre_reg);
    // carrier restarts on the rising word counter output
    assign sync_align = sync_reg && word_out_reg && !word_prev_reg
        && byte_ctrl_reg[`DCCT_CTL_RUN];
    assign byte_load = (byte_ctrl_reg[7] && !byte_run_q_reg)
        || byte_cap_ev || sync_align;
    assign word_load = (word_ctrl_reg[7] && !word_run_q_reg)
        || word_cap_ev;
    assign byte_ld = byte_ctrl_reg[`DCCT_CTL_BYTE_CAPMODE] ? `DCCT_BYTE_FULL
        : (byte_out_reg ? byte_hold_lo_reg : byte_hold_hi_reg);

    dcct_counter #(.WIDTH(8)) u_byte (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .tick_in(byte_tick),
        .run_in(byte_ctrl_reg[`DCCT_CTL_RUN]),
        .load_in(byte_load),
        .load_val_in(byte_ld),
        .count_out(byte_count),
        .tc_out(byte_tc)
    );

    dcct_counter #(.WIDTH(16)) u_word (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .tick_in(word_tick),
        .run_in(word_ctrl_reg[`DCCT_CTL_RUN]),
        .load_in(word_load),
        .load_val_in(word_hold_reg),
        .count_out(word_count),
        .tc_out(word_tc)
    );

    // register writes, status flags and captures
    always_comb
    begin
        byte_ctrl_next = byte_ctrl_reg;
        shared_next = shared_reg;
        word_ctrl_next = word_ctrl_reg;
        sync_next = sync_reg;
        byte_hold_lo_next = byte_hold_lo_reg;
        byte_hold_hi_next = byte_hold_hi_reg;
        word_hold_next = word_hold_reg;
        word_cap_next = word_cap_reg;
        byte_cap_lo_next = byte_cap_lo_reg;
        byte_cap_hi_next = byte_cap_hi_reg;
        if (wr_take)
        begin
            if (idx == `DCCT_IDX_BYTE_CTRL)
            begin
                byte_ctrl_next = {wd[7:6], byte_ctrl_reg[5] && !wd[5],
                                  wd[4:0]};
            end
            else if (idx == `DCCT_IDX_SHARED)
            begin
                shared_next = {wd[7:2], shared_reg[1:0] & ~wd[1:0]};
            end
            else if (idx == `DCCT_IDX_WORD_CTRL)
            begin
                word_ctrl_next = {wd[7:6], word_ctrl_reg[5] && !wd[5],
                                  wd[4:0]};
            end
            else if (idx == `DCCT_IDX_RUN_SYNC)
            begin
                word_ctrl_next[`DCCT_CTL_RUN] = wd[`DCCT_RS_WORD_RUN];
                byte_ctrl_next[`DCCT_CTL_RUN] = wd[`DCCT_RS_BYTE_RUN];
                sync_next = wd[`DCCT_RS_SYNC];
            end
            else if (idx == `DCCT_IDX_BYTE_HOLD_LO)
            begin
                byte_hold_lo_next = wd;
            end
            else if (idx == `DCCT_IDX_BYTE_HOLD_HI)
            begin
                byte_hold_hi_next = wd;
            end
            else if (idx == `DCCT_IDX_WORD_HOLD_LO)
            begin
                word_hold_next[7:0] = wd;
            end
            else if (idx == `DCCT_IDX_WORD_HOLD_HI)
            begin
                word_hold_next[15:8] = wd;
            end
            // capture registers and others: write ignored
        end
        // hardware sets win over software clears
        if (byte_tc)
        begin
            byte_ctrl_next[`DCCT_CTL_TIMEOUT] = 1'b1;
            if (byte_ctrl_reg[`DCCT_CTL_ONESHOT])
            begin
                byte_ctrl_next[`DCCT_CTL_RUN] = 1'b0;
            end
        end
        if (word_tc)
        begin
            word_ctrl_next[`DCCT_CTL_TIMEOUT] = 1'b1;
            if (word_ctrl_reg[`DCCT_CTL_ONESHOT])
            begin
                word_ctrl_next[`DCCT_CTL_RUN] = 1'b0;
            end
        end
        if (rise)
        begin
            shared_next[`DCCT_SH_FLAG_RISE] = 1'b1;
        end
        if (fall)
        begin
            shared_next[`DCCT_SH_FLAG_FALL] = 1'b1;
        end
        if (word_cap_ev)
        begin
            word_cap_next = word_hold_reg - word_count;
        end
        if (byte_cap_ev && prev_reg)
        begin
            byte_cap_hi_next = `DCCT_BYTE_FULL - byte_count;
        end
        if (byte_cap_ev && !prev_reg)
        begin
            byte_cap_lo_next = `DCCT_BYTE_FULL - byte_count;
        end
    end

    // read mux, wait state and counter side next values
    always_comb
    begin
        rdata_next = rdata_reg;
        wait_next = !(avs_read_in || avs_write_in) || !wait_reg;
        if (rd_take)
        begin
            rdata_next = 32'h0000_0000;
            if (idx == `DCCT_IDX_BYTE_CTRL)
                rdata_next[7:0] = byte_ctrl_reg;
            else if (idx == `DCCT_IDX_SHARED)
                rdata_next[7:0] = shared_reg;
            else if (idx == `DCCT_IDX_WORD_CTRL)
                rdata_next[7:0] = word_ctrl_reg;
            else if (idx == `DCCT_IDX_RUN_SYNC)
                rdata_next[7:0] = {word_ctrl_reg[7], byte_ctrl_reg[7],
                                   sync_reg, `DCCT_RS_RSVD};
            else if (idx == `DCCT_IDX_BYTE_HOLD_LO)
                rdata_next[7:0] = byte_hold_lo_reg;
            else if (idx == `DCCT_IDX_BYTE_HOLD_HI)
                rdata_next[7:0] = byte_hold_hi_reg;
            else if (idx == `DCCT_IDX_WORD_HOLD_LO)
                rdata_next[7:0] = word_hold_reg[7:0];
            else if (idx == `DCCT_IDX_WORD_HOLD_HI)
                rdata_next[7:0] = word_hold_reg[15:8];
            else if (idx == `DCCT_IDX_WORD_CAP_LO)
                rdata_next[7:0] = word_cap_reg[7:0];
            else if (idx == `DCCT_IDX_WORD_CAP_HI)
                rdata_next[7:0] = word_cap_reg[15:8];
            else if (idx == `DCCT_IDX_BYTE_CAP_LO)
                rdata_next[7:0] = byte_cap_lo_reg;
            else if (idx == `DCCT_IDX_BYTE_CAP_HI)
                rdata_next[7:0] = byte_cap_hi_reg;
        end
        pre_next = pre_reg + 3'h1;
        prev_next = lvl;
        word_prev_next = word_out_reg;
        edge_seen_next = (edge_seen_reg || word_cap_ev) && !word_load
            && word_ctrl_reg[7];
        if (word_cap_ev)
            edge_seen_next = 1'b1;
        byte_out_next = sync_align ? 1'b1 : (byte_out_reg ^ byte_tc);
        word_out_next = word_out_reg ^ word_tc;
        word_pin_next = word_ctrl_reg[`DCCT_CTL_PINSEL] ? word_out_reg
                                           : word_port_data_in;
        byte_pin_next = byte_ctrl_reg[`DCCT_CTL_PINSEL] ? byte_out_reg
                                           : byte_port_data_in;
        interrupt_line_three_next = (word_tc && word_ctrl_reg[`DCCT_CTL_TOIE])
            || (word_cap_ev && word_ctrl_reg[`DCCT_CTL_WORD_CAPIE]);
        interrupt_line_four_next = byte_tc && byte_ctrl_reg[`DCCT_CTL_TOIE];
    end

    // register and status flip-flops; sync bit cleared here on reset or by a run and sync write with bit 5 low
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            byte_ctrl_reg <= `DCCT_BYTE_RST;
            shared_reg <= `DCCT_BYTE_RST;
            word_ctrl_reg <= `DCCT_BYTE_RST;
            sync_reg <= 1'b0;
            byte_hold_lo_reg <= `DCCT_BYTE_RST;
            byte_hold_hi_reg <= `DCCT_BYTE_RST;
            word_hold_reg <= `DCCT_WORD_RST;
            word_cap_reg <= `DCCT_WORD_RST;
            byte_cap_lo_reg <= `DCCT_BYTE_RST;
            byte_cap_hi_reg <= `DCCT_BYTE_RST;
            rdata_reg <= 32'h0000_0000;
            wait_reg <= 1'b1;
        end
        else
        begin
            byte_ctrl_reg <= byte_ctrl_next;
            shared_reg <= shared_next;
            word_ctrl_reg <= word_ctrl_next;
            sync_reg <= sync_next;
            byte_hold_lo_reg <= byte_hold_lo_next;
            byte_hold_hi_reg <= byte_hold_hi_next;
            word_hold_reg <= word_hold_next;
            word_cap_reg <= word_cap_next;
            byte_cap_lo_reg <= byte_cap_lo_next;
            byte_cap_hi_reg <= byte_cap_hi_next;
            rdata_reg <= rdata_next;
            wait_reg <= wait_next;
        end
    end

    // pin synchronisers, counter side state and outputs
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            prev_reg <= 1'b0;
            pre_reg <= 3'h0;
            word_prev_reg <= 1'b0;
            edge_seen_reg <= 1'b0;
            byte_run_q_reg <= 1'b0;
            word_run_q_reg <= 1'b0;
            byte_out_reg <= 1'b0;
            word_out_reg <= 1'b0;
            word_pin_reg <= 1'b0;
            byte_pin_reg <= 1'b0;
            interrupt_line_three_reg <= 1'b0;
            interrupt_line_four_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= {alternate_edge_input_in,
                          comparator_capable_input_in};
            sync2_reg <= sync1_reg;
            prev_reg <= prev_next;
            pre_reg <= pre_next;
            word_prev_reg <= word_prev_next;
            edge_seen_reg <= edge_seen_next;
            byte_run_q_reg <= byte_ctrl_reg[`DCCT_CTL_RUN];
            word_run_q_reg <= word_ctrl_reg[`DCCT_CTL_RUN];
            byte_out_reg <= byte_out_next;
            word_out_reg <= word_out_next;
            word_pin_reg <= word_pin_next;
            byte_pin_reg <= byte_pin_next;
            interrupt_line_three_reg <= interrupt_line_three_next;
            interrupt_line_four_reg <= interrupt_line_four_next;
        end
    end

    assign avs_readdata_out = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign word_counter_output_pin_out = word_pin_reg;
    assign byte_counter_output_pin_out = byte_pin_reg;
    assign interrupt_line_three_out = interrupt_line_three_reg;
    assign interrupt_line_four_out = interrupt_line_four_reg;
endmodule // dcct_timers
`default_nettype wire

// ### verif/dcct_timers_checker.sv
`timescale 1ns/1ps
`default_nettype none
// bus handshake and interrupt pulse timing seen at the top ports
module dcct_timers_checker (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic interrupt_line_three_out,
    input wire logic interrupt_line_four_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    logic req;
    logic rd_done;
    // a request and a read answered at this edge
    assign req = avs_read_in || avs_write_in;
    assign rd_done = avs_read_in && !avs_waitrequest_out;
    // one wait state, then back to high
    AST_BUS_ANSWER:
        assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("request not answered after one wait");
    AST_BUS_ONE_LOW:
        assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low longer than one cycle");
    AST_BUS_IDLE:
        assert property (!req && avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest dropped without a request");
    AST_RD_UPPER:
        assert property (avs_readdata_out[31:8] == 24'h000000)
        else $error("upper read data not zero");
    AST_RS_RSVD:
        assert property (rd_done && avs_address_in[5:2] == 4'h3
            |-> avs_readdata_out[4:0] == 5'h1F)
        else $error("run and sync reserved bits wrong");
    AST_UNMAPPED:
        assert property (rd_done && avs_address_in[5:2] >= 4'hC
            |-> avs_readdata_out == 32'h00000000)
        else $error("unmapped read not zero");
    AST_INTERRUPT_LINE_FOUR_PULSE:
        assert property (interrupt_line_four_out |=> !interrupt_line_four_out)
        else $error("byte interrupt longer than one cycle");
    AST_INTERRUPT_LINE_THREE_PULSE:
        assert property ($rose(interrupt_line_three_out)
            |=> $fell(interrupt_line_three_out))
        else $error("word interrupt longer than one cycle");
endmodule // dcct_timers_checker
`default_nettype wire
bind dcct_timers dcct_timers_checker dcct_timers_checker_i (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .interrupt_line_three_out(interrupt_line_three_out),
    .interrupt_line_four_out(interrupt_line_four_out)
);

// ### verif/dcct_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
// external pulse source feeding one of the two edge inputs
module dcct_pulse_src (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic run_in,
    input wire logic alt_in,
    input wire logic [7:0] high_len_in,
    input wire logic [7:0] low_len_in,
    output logic comparator_pin_out,
    output logic alternate_pin_out
);
    logic level_reg;
    logic [7:0] left_reg;
    // square wave in clock cycles, held low while stopped
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            level_reg <= 1'b0;
            left_reg <= 8'h00;
        end
        else if (!run_in)
        begin
            level_reg <= 1'b0;
            left_reg <= low_len_in;
        end
        else if (left_reg <= 8'h01)
        begin
            level_reg <= !level_reg;
            left_reg <= level_reg ? low_len_in : high_len_in;
        end
        else
        begin
            left_reg <= left_reg - 8'h01;
        end
    end
    // only the chosen pin carries pulses, the other idles low
    assign comparator_pin_out = level_reg & !alt_in;
    assign alternate_pin_out = level_reg & alt_in;
endmodule // dcct_pulse_src
`default_nettype wire

// ### verif/dcct_timers_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
    begin \
        n_tests++; \
        if ((gt) !== (ex)) \
        begin \
            fail_count++; \
            $display("BAD %s exp %h got %h", nm, ex, gt); \
        end \
    end
module dcct_timers_test;
    logic mclk_in, resetn_in, avs_read_in, avs_write_in;
    logic [5:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, r;
    logic [3:0] avs_byteenable_in;
    logic avs_waitrequest_out, cmp_pin, alt_pin, w_port, b_port;
    logic w_pin, b_pin, interrupt_line_three, interrupt_line_four, p_run, p_alt;
    logic [7:0] hl, ll, a, d;
    int seed, fail_count, n_tests, cyc, cnt3, cnt4, b3, b4, p, q, n, c, os;
    dcct_timers dcct_timers_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .comparator_capable_input_in(cmp_pin),
        .alternate_edge_input_in(alt_pin), .word_port_data_in(w_port),
        .byte_port_data_in(b_port), .word_counter_output_pin_out(w_pin),
        .byte_counter_output_pin_out(b_pin),
        .interrupt_line_three_out(interrupt_line_three), .interrupt_line_four_out(interrupt_line_four));
    dcct_pulse_src dcct_pulse_src_i (.mclk_in(mclk_in),
        .resetn_in(resetn_in), .run_in(p_run), .alt_in(p_alt),
        .high_len_in(hl), .low_len_in(ll), .comparator_pin_out(cmp_pin),
        .alternate_pin_out(alt_pin));
    // 20 MHz clock
    initial
    begin
        mclk_in = 1'b0;
        forever #25 mclk_in = !mclk_in;
    end
    // verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // interrupt pulse counters and hang guard
    always @(posedge mclk_in)
    begin
        cnt3 += (interrupt_line_three === 1'b1);
        cnt4 += (interrupt_line_four === 1'b1);
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            tally_and_finish;
        end
    end
    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input int idx, input logic [7:0] wd,
        output logic [7:0] rd);
        avs_address_in <= {idx[3:0], 2'b00};
        avs_writedata_in <= {24'h000000, wd};
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do
            @(posedge mclk_in);
        while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out[7:0];
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic wreg(input int idx, input logic [7:0] wd);
        logic [7:0] x;
        bus(1'b1, idx, wd, x);
    endtask
    // capture agrees with a pulse length within the partial tick
    function automatic logic near(input logic [15:0] v, input logic [7:0] e);
        return (v + 16'h0002 >= {8'h00, e}) && (v <= {8'h00, e} + 16'h0002);
    endfunction
    // main sequence
    initial
    begin
        seed = 49804;
        {fail_count, n_tests, cyc, cnt3, cnt4} = '0;
        {avs_read_in, avs_write_in, w_port, b_port, p_run, p_alt} = '0;
        avs_address_in = 6'h00;
        avs_writedata_in = 32'h00000000;
        avs_byteenable_in = 4'hF;
        hl = 8'h10;
        ll = 8'h10;
        resetn_in = 1'b0;
        repeat (6) @(posedge mclk_in);
        resetn_in <= 1'b1;
        @(posedge mclk_in);
        bus(1'b0, 3, 8'h00, d);
        `CHK("run_sync", 8'h1F, d)
        for (int i = 8; i < 16; i++)
        begin
            r = $random(seed);
            wreg(i, r[7:0]);
            bus(1'b0, i, 8'h00, d);
            `CHK("cap_ro", 8'h00, d)
        end
        // clear status with plain writes, no read-modify-write
        wreg(0, 8'h20);
        wreg(2, 8'h20);
        wreg(1, 8'h03);
        $display("test registers done");
        for (c = 0; c < 2; c++)
            for (os = 1; os >= 0; os--)
            begin
                n = 3 + ($random(seed) & 7);
                wreg(4 + 2 * c, 8'(n));
                wreg(5 + 2 * c, c ? 8'h00 : 8'(n));
                {b3, b4} = {cnt3, cnt4};
                wreg(2 * c, {1'b1, os[0], 6'h02});
                repeat (10 * (n + 1)) @(posedge mclk_in);
                p = c ? cnt3 - b3 : cnt4 - b4;
                q = c ? cnt4 - b4 : cnt3 - b3;
                `CHK("tc_cnt", 1'b1, os ? p == 1 : p > 8 && p < 12)
                `CHK("other_irq", 0, q)
                bus(1'b0, 2 * c, 8'h00, d);
                `CHK("timeout", 2'b10 | !os, {d[5], d[7]})
                bus(1'b0, 3, 8'h00, d);
                `CHK("rs_run", !os, d[6 + c])
                wreg(2 * c, 8'h00);
                bus(1'b0, 2 * c, 8'h00, d);
                `CHK("w0_keep", 1'b1, d[5])
                wreg(2 * c, 8'h20);
                bus(1'b0, 2 * c, 8'h00, d);
                `CHK("w1_clear", 1'b0, d[5])
            end
        $display("test timeout done");
        hl <= 8'(8 + ($random(seed) & 31));
        ll <= 8'(8 + ($random(seed) & 31));
        wreg(6, 8'hFF);
        wreg(7, 8'hFF);
        wreg(1, 8'h24);
        b3 = cnt3;
        wreg(2, 8'h84);
        wreg(0, 8'h84);
        p_run <= 1'b1;
        repeat (4 * (hl + ll) + 10) @(posedge mclk_in);
        wreg(2, 8'h00);
        wreg(0, 8'h00);
        p_run <= 1'b0;
        `CHK("cap_irq", 1'b1, cnt3 - b3 >= 6)
        bus(1'b0, 8, 8'h00, a);
        bus(1'b0, 9, 8'h00, d);
        `CHK("word_cap", 1'b1, near({d,a}, hl) || near({d,a}, ll))
        bus(1'b0, 11, 8'h00, d);
        `CHK("byte_cap_hi", 1'b1, near({8'h00, d}, hl))
        bus(1'b0, 10, 8'h00, d);
        `CHK("byte_cap_lo", 1'b1, near({8'h00, d}, ll))
        $display("test demod done");
        repeat (10) @(posedge mclk_in);
        wreg(1, 8'hAC);
        b3 = cnt3;
        wreg(2, 8'h84);
        p_alt <= 1'b1;
        p_run <= 1'b1;
        repeat (4 * (hl + ll)) @(posedge mclk_in);
        wreg(2, 8'h00);
        `CHK("first_only", 1, cnt3 - b3)
        $display("test first edge done");
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            w_port <= r[0];
            b_port <= r[1];
            repeat (3) @(posedge mclk_in);
            `CHK("port_pin", r[1:0], {b_pin, w_pin})
        end
        $display("test pins done");
        // counters drive the pins: byte toggles every 4 clocks, word every 8
        wreg(4, 8'h03);
        wreg(5, 8'h03);
        wreg(6, 8'h03);
        wreg(7, 8'h00);
        wreg(0, 8'h81);
        wreg(2, 8'h89);
        repeat (12) @(posedge mclk_in);
        a = {6'h00, b_pin, w_pin};
        repeat (4) @(posedge mclk_in);
        `CHK("byte_out", !a[1], b_pin)
        repeat (4) @(posedge mclk_in);
        `CHK("word_out", !a[0], w_pin)
        // sync mode forces the carrier high on each word output rise
        wreg(4, 8'h40);
        wreg(5, 8'h40);
        wreg(3, 8'hE0);
        repeat (20) @(posedge mclk_in);
        `CHK("sync_pin", 1'b1, b_pin)
        wreg(3, 8'h20);
        bus(1'b0, 3, 8'h00, d);
        `CHK("rs_sync", 8'h3F, d)
        // a reset in mid-run clears the sync bit
        resetn_in <= 1'b0;
        @(posedge mclk_in);
        resetn_in <= 1'b1;
        @(posedge mclk_in);
        bus(1'b0, 3, 8'h00, d);
        `CHK("rs_reset", 8'h1F, d)
        $display("test outputs done");
        tally_and_finish;
    end
endmodule // dcct_timers_test
`default_nettype wire
